// ### logic/sdc_ctrl.sv
// Purpose: Host-side sequencer that drives a four-bank SDRAM with legal command spacing.
// Assumes: Single-word accesses, one row open at a time, closed after each access.
// Notes:   Read data passes two sync flops, so read latency is longer than the device's.
`default_nettype none
module sdc_ctrl #(
    parameter int GRADE        = 2,                 // 0 fastest .. 2 slowest
    parameter bit HOT_GRADE    = 1'b0,              // Use the short refresh window
    parameter bit AUTO_PRE_WR  = 1'b0,              // Writes close the row themselves
    parameter int POWERUP_CYC  = sdc_pkg::POWERUP_US * 1000 / sdc_pkg::CLK_PERIOD_NS,
    parameter int REFI_CYC     = sdc_pkg::cyc_dn(
        (HOT_GRADE ? longint'(sdc_pkg::REFRESH_WINDOW_HOT_MS) : longint'(sdc_pkg::REFRESH_WINDOW_MS))
        * 1000000 / sdc_pkg::REF_ROWS)
) (
    input  wire logic             CLK,
    input  wire logic             RSTN,
    input  wire logic             REQ_VALID,
    input  wire sdc_pkg::sdc_req_t REQ,
    output logic                  REQ_READY,
    output logic                  RD_VALID,
    output logic [15:0]           RD_DATA,
    input  wire logic             SLEEP_REQ,
    output logic                  SLEEPING,
    output logic                  INIT_DONE,
    output logic                  SD_CKE,
    output sdc_pkg::sdc_cmd_t     SD_CMD,
    output logic [1:0]            SD_BA,
    output logic [11:0]           SD_ADDR,
    output logic [1:0]            SD_DQM,
    output logic [15:0]           SD_DQ_O,
    output logic                  SD_DQ_OE,
    input  wire logic [15:0]      SD_DQ_I
);
    import sdc_pkg::*;

    // Cycle counts, rounded up from ns figures except the longest open time
    localparam int RC_CYC   = cyc_up(T_RC_NS[GRADE]);
    localparam int RAS_CYC  = cyc_up(T_RAS_NS[GRADE]);
    localparam int RASX_CYC = cyc_dn(longint'(T_RAS_MAX_NS)); // Longest open time, rounded down
    localparam int RP_CYC   = cyc_up(T_RP_NS[GRADE]);
    localparam int RCD_CYC  = cyc_up(T_RCD_NS[GRADE]);
    localparam int RRD_CYC  = cyc_up(T_RRD_NS[GRADE]);
    localparam int XSR_CYC  = cyc_up(T_XSR_NS[GRADE]);
    localparam int CKA_CYC  = T_CKA_CLK + cyc_up(T_CKA_NS);
    localparam int DAL_CYC  = T_WR_CLK + RP_CYC;
    // One gap counter serves row cycle and bank-to-bank spacing
    localparam int GAP_CYC  = (RC_CYC > RRD_CYC) ? RC_CYC : RRD_CYC;

    sdc_state_t         state_reg;         // Sequencer state
    logic [WAIT_W-1:0]  wait_reg;          // Cycles left before next command
    logic [WAIT_W-1:0]  since_act_reg;     // Cycles since last activate or refresh
    logic [WAIT_W-1:0]  refi_reg;          // Refresh interval countdown
    logic               ref_pend_reg;      // A refresh is owed
    logic [1:0]         init_refs_reg;     // Init refreshes still to do
    logic [3:0]         rd_pipe_reg;       // Read capture countdown
    sdc_req_t           req_reg;           // Accepted request
    logic [15:0]        dq_s1_reg;         // First sync stage, read only by second
    logic [15:0]        dq_s2_reg;         // Second sync stage
    logic               wait_done;         // No spacing wait pending
    logic               do_ref;            // Refresh command goes out now

    assign wait_done = (wait_reg == '0);
    assign do_ref    = (state_reg == ST_REF) && wait_done && (since_act_reg >= WAIT_W'(GAP_CYC));
    assign REQ_READY = (state_reg == ST_IDLE) && wait_done && INIT_DONE && !ref_pend_reg && !SLEEP_REQ;

    // Two-flop synchroniser on the read data pins
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            dq_s1_reg <= '0;
            dq_s2_reg <= '0;
        end else begin
            dq_s1_reg <= SD_DQ_I;
            dq_s2_reg <= dq_s1_reg;
        end
    end

    // Time since last activate or refresh, saturating
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            since_act_reg <= '1;
        end else if ((SD_CMD == CMD_ACT) || (SD_CMD == CMD_REF)) begin
            since_act_reg <= '0;
        end else if (since_act_reg != '1) begin
            since_act_reg <= since_act_reg + WAIT_W'(1);
        end
    end

    // Refresh interval timer; owed refresh set wins over its clear
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            refi_reg     <= '0;
            ref_pend_reg <= 1'b0;
        end else if (!INIT_DONE || SLEEPING) begin
            // Device refreshes itself while asleep; restart on wake
            refi_reg     <= WAIT_W'(REFI_CYC);
            ref_pend_reg <= 1'b0;
        end else if (refi_reg == '0) begin
            refi_reg     <= WAIT_W'(REFI_CYC);
            ref_pend_reg <= 1'b1;
        end else begin
            refi_reg <= refi_reg - WAIT_W'(1);
            if (do_ref) begin
                ref_pend_reg <= 1'b0;
            end
        end
    end

    // Read data capture after the pipeline delay
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rd_pipe_reg <= '0;
            RD_VALID    <= 1'b0;
            RD_DATA     <= '0;
        end else begin
            RD_VALID <= 1'b0;
            if (SD_CMD == CMD_READ) begin
                rd_pipe_reg <= 4'(RD_PIPE - 1);   // Seen one edge after the decision
            end else if (rd_pipe_reg != '0) begin
                rd_pipe_reg <= rd_pipe_reg - 4'd1;
                if (rd_pipe_reg == 4'd1) begin
                    RD_VALID <= 1'b1;
                    RD_DATA  <= dq_s2_reg;
                end
            end
        end
    end

    // Main sequencer: one command per cycle, NOP while waiting
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_reg     <= ST_PWR;
            wait_reg      <= '0;
            init_refs_reg <= '0;
            req_reg       <= '0;
            INIT_DONE     <= 1'b0;
            SLEEPING      <= 1'b0;
            SD_CKE        <= 1'b1;
            SD_CMD        <= CMD_NOP;
            SD_BA         <= '0;
            SD_ADDR       <= '0;
            SD_DQM        <= 2'b11;
            SD_DQ_O       <= '0;
            SD_DQ_OE      <= 1'b0;
        end else begin
            // Defaults: no command, bus released
            SD_CMD   <= CMD_NOP;
            SD_DQ_OE <= 1'b0;
            if (!wait_done) begin
                wait_reg <= wait_reg - WAIT_W'(1);
            end
            case (state_reg)
                ST_PWR: begin
                    // Hold NOPs with DQM high until the supplies settle
                    if (wait_reg == '0 && init_refs_reg == '0) begin
                        wait_reg      <= WAIT_W'(POWERUP_CYC);
                        init_refs_reg <= 2'(INIT_REFS);
                    end else if (wait_done) begin
                        state_reg <= ST_IPRE;
                    end
                end
                ST_IPRE: begin
                    // Close every bank before the refreshes
                    SD_CMD           <= CMD_PRE;
                    SD_ADDR          <= '0;
                    SD_ADDR[AP_BIT]  <= 1'b1;
                    wait_reg         <= WAIT_W'(RP_CYC - 1);
                    state_reg        <= ST_IREF;
                end
                ST_IREF: begin
                    if (wait_done && since_act_reg >= WAIT_W'(GAP_CYC)) begin
                        SD_CMD        <= CMD_REF;
                        init_refs_reg <= init_refs_reg - 2'd1;
                        wait_reg      <= WAIT_W'(RC_CYC - 1);          // Gap counter lags a cycle
                        if (init_refs_reg == 2'd1) begin
                            state_reg <= ST_IMRS;
                        end
                    end
                end
                ST_IMRS: begin
                    if (wait_done && since_act_reg >= WAIT_W'(GAP_CYC)) begin
                        SD_CMD    <= CMD_LMR;
                        SD_BA     <= '0;
                        SD_ADDR   <= MODE_WORD;
                        wait_reg  <= WAIT_W'(T_MRD_CLK - 1);
                        state_reg <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    // Accesses only after init finished and mode spacing elapsed
                    if (wait_done) begin
                        INIT_DONE <= 1'b1;
                        SD_DQM    <= 2'b00;
                        if (ref_pend_reg) begin
                            state_reg <= ST_REF;                       // Refresh beats requests
                        end else if (SLEEP_REQ) begin
                            state_reg <= ST_REF;
                        end else if (REQ_VALID && INIT_DONE) begin
                            req_reg   <= REQ;
                            state_reg <= ST_ACT;
                        end
                    end
                end
                ST_ACT: begin
                    // Gap counter covers row cycle and bank-to-bank spacing
                    if (wait_done && since_act_reg >= WAIT_W'(GAP_CYC)) begin
                        SD_CMD    <= CMD_ACT;
                        SD_BA     <= req_reg.bank;
                        SD_ADDR   <= req_reg.row;
                        wait_reg  <= WAIT_W'(RCD_CYC - 1);
                        state_reg <= ST_RW;
                    end
                end
                ST_RW: begin
                    if (wait_done) begin
                        SD_BA           <= req_reg.bank;
                        SD_ADDR         <= {4'h0, req_reg.col};
                        SD_ADDR[AP_BIT] <= req_reg.write && AUTO_PRE_WR;
                        if (req_reg.write) begin
                            // Write data goes with the command
                            SD_CMD   <= CMD_WRITE;
                            SD_DQ_O  <= req_reg.wdata;
                            SD_DQ_OE <= 1'b1;
                            if (AUTO_PRE_WR) begin
                                wait_reg  <= WAIT_W'(DAL_CYC - 1);
                                state_reg <= ST_IDLE;
                            end else begin
                                wait_reg  <= WAIT_W'(T_WR_CLK - 1);
                                state_reg <= ST_PRE;
                            end
                        end else begin
                            SD_CMD    <= CMD_READ;
                            wait_reg  <= WAIT_W'(RD_PIPE);
                            state_reg <= ST_RDWAIT;
                        end
                    end
                end
                ST_RDWAIT: begin
                    // Keep the row until the read word is captured
                    if (wait_done) begin
                        state_reg <= ST_PRE;
                    end
                end
                ST_PRE: begin
                    // Close no earlier than the minimum open time; the access is short
                    // enough that the 100 us ceiling is never approached
                    if (wait_done && since_act_reg >= WAIT_W'(RAS_CYC)
                        && since_act_reg < WAIT_W'(RASX_CYC)) begin
                        SD_CMD           <= CMD_PRE;
                        SD_BA            <= req_reg.bank;
                        SD_ADDR[AP_BIT]  <= 1'b0;
                        wait_reg         <= WAIT_W'(RP_CYC - 1);
                        state_reg        <= ST_IDLE;
                    end
                end
                ST_REF: begin
                    // Auto refresh, or self refresh entry with clock enable low
                    if (do_ref) begin
                        SD_CMD <= CMD_REF;
                        if (SLEEP_REQ && !ref_pend_reg) begin
                            SD_CKE    <= 1'b0;
                            SLEEPING  <= 1'b1;
                            state_reg <= ST_SRHOLD;
                        end else begin
                            wait_reg  <= WAIT_W'(RC_CYC - 1);
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_SRHOLD: begin
                    if (!SLEEP_REQ) begin
                        SD_CKE    <= 1'b1;
                        wait_reg  <= WAIT_W'(CKA_CYC);
                        state_reg <= ST_SREXIT;
                    end
                end
                ST_SREXIT: begin
                    // NOPs through recovery, then the exit time before any activate
                    if (wait_done) begin
                        SLEEPING  <= 1'b0;
                        wait_reg  <= WAIT_W'(XSR_CYC - 1);
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_PWR;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### logic/sdc_pkg.sv
// Purpose: Constants and carrier types for the SDRAM command sequencer.
// Assumes: One 100 MHz clock; the attached SDRAM is x16 with four banks.
// Notes:   Times are kept in the units printed (ns, us, ms or clocks); cycle counts derive from them.
`default_nettype none
package sdc_pkg;
    localparam int CLK_PERIOD_NS = 10;               // 100 MHz system clock
    // Speed grade tables, index 0 fastest, 2 slowest
    localparam int T_RC_NS   [3] = '{55, 60, 63};
    localparam int T_RAS_NS  [3] = '{40, 42, 42};
    localparam int T_RP_NS   [3] = '{15, 18, 20};
    localparam int T_RCD_NS  [3] = '{15, 18, 20};
    localparam int T_RRD_NS  [3] = '{10, 12, 14};
    localparam int T_XSR_NS  [3] = '{60, 66, 70};
    localparam int T_RAS_MAX_NS  = 100000;
    localparam int T_WR_CLK      = 2;                // Last write data to precharge
    localparam int T_MRD_CLK     = 2;                // Mode load to activate/refresh
    localparam int T_CKA_CLK     = 1;                // Clock part of clock_enable_recovery_gap
    localparam int T_CKA_NS      = 3;                // Extra ns of clock_enable_recovery_gap
    localparam int POWERUP_US    = 200;
    localparam int REF_ROWS      = 4096;
    localparam int REFRESH_WINDOW_MS    = 64;        // Normal temperature grades
    localparam int REFRESH_WINDOW_HOT_MS = 16;       // High-temperature grade
    localparam int CAS_LAT       = 2;                // 10 ns clock allows latency 2
    localparam int RD_PIPE       = CAS_LAT + 3;      // Command reg + latency + two sync flops
    localparam int WAIT_W        = 16;
    localparam int INIT_REFS     = 2;
    // Mode word: burst 1, sequential, latency 2, normal write bursts
    localparam logic [11:0] MODE_WORD = 12'h020;
    localparam int AP_BIT        = 10;               // Address bit for auto/all precharge

    // Round a ns interval up to clocks, never below one
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Round a ns interval down to clocks, never below one
    function automatic int cyc_dn(input longint ns);
        longint c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : int'(c);
    endfunction

    // Command pins, all active low
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } sdc_cmd_t;

    localparam sdc_cmd_t CMD_NOP   = '{1'b0, 1'b1, 1'b1, 1'b1};
    localparam sdc_cmd_t CMD_ACT   = '{1'b0, 1'b0, 1'b1, 1'b1};
    localparam sdc_cmd_t CMD_READ  = '{1'b0, 1'b1, 1'b0, 1'b1};
    localparam sdc_cmd_t CMD_WRITE = '{1'b0, 1'b1, 1'b0, 1'b0};
    localparam sdc_cmd_t CMD_PRE   = '{1'b0, 1'b0, 1'b1, 1'b0};
    localparam sdc_cmd_t CMD_REF   = '{1'b0, 1'b0, 1'b0, 1'b1};
    localparam sdc_cmd_t CMD_LMR   = '{1'b0, 1'b0, 1'b0, 1'b0};

    // User request: bank, row, column and write word
    typedef struct packed {
        logic        write;
        logic [1:0]  bank;
        logic [11:0] row;
        logic [7:0]  col;
        logic [15:0] wdata;
    } sdc_req_t;

    typedef enum {
        ST_PWR, ST_IPRE, ST_IREF, ST_IMRS, ST_IDLE, ST_ACT, ST_RW,
        ST_RDWAIT, ST_PRE, ST_REF, ST_SRHOLD, ST_SREXIT
    } sdc_state_t;
endpackage
`default_nettype wire

// ### test/sdc_ctrl_asserts.sv
// Purpose: Command spacing checks on the sequencer's SDRAM pins.
// Assumes: Slowest grade at 10 ns, so ns gaps round up to whole cycles.
// Notes:   Repeat counts are literal and hold only for that grade.
`default_nettype none
module sdc_ctrl_asserts
    import sdc_pkg::*;
#(
    parameter int POWERUP_CYC = 50
) (
    input wire logic              CLK,
    input wire logic              RSTN,
    input wire logic              INIT_DONE,
    input wire logic              SD_CKE,
    input wire sdc_pkg::sdc_cmd_t SD_CMD
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic  is_act = SD_CMD == CMD_ACT;   // Row open
    wire logic  is_ref = SD_CMD == CMD_REF;   // Refresh
    wire logic  is_pre = SD_CMD == CMD_PRE;   // Row close
    wire logic  is_wr  = SD_CMD == CMD_WRITE; // Write, data on the same edge
    wire logic  is_acc = is_wr || SD_CMD == CMD_READ;
    wire logic  is_lmr = SD_CMD == CMD_LMR;   // Mode load
    wire logic  is_nop = SD_CMD == CMD_NOP;   // Idle command
    logic [15:0] up_reg;                      // Cycles since reset, saturating
    logic [1:0]  refs_reg;                    // Refreshes issued during init

    // Power-up age; saturates so a long run never wraps
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) up_reg <= 16'h0000;
        else if (up_reg != 16'hffff) up_reg <= up_reg + 16'h0001;
    end

    // Init refresh count, frozen once init is over
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) refs_reg <= 2'h0;
        else if (is_ref && !INIT_DONE && refs_reg != 2'h3) refs_reg <= refs_reg + 2'h1;
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // Row cycle of 7 clocks also covers the cross-bank gap of 2
    a_rc_gap: assert property ((is_act || is_ref) |=> !(is_act || is_ref) [*6])
        else $error("row open or refresh too soon after the last");
    a_ras_min: assert property (is_act |=> !is_pre [*4])
        else $error("row closed too soon after opening");
    a_rp_gap: assert property (is_pre |=> !(is_act || is_ref))
        else $error("row opened too soon after close");
    a_rcd_gap: assert property (is_act |=> !is_acc)
        else $error("access too soon after row open");
    a_wr_pre: assert property (is_wr |=> !is_pre)
        else $error("close too soon after write data");
    a_cke_recover: assert property ($rose(SD_CKE) |-> is_nop [*2])
        else $error("command too soon after clock enable");
    a_sr_exit: assert property ($rose(SD_CKE) |-> !is_act [*7])
        else $error("row open too soon after self refresh");
    a_init_first: assert property (is_acc || is_act |-> INIT_DONE)
        else $error("access before init finished");
    a_init_order: assert property (is_lmr && !INIT_DONE |-> refs_reg >= 2'h2)
        else $error("mode load before two refreshes");
    a_mrd_gap: assert property (is_lmr |=> !(is_act || is_ref))
        else $error("command too soon after mode load");
    a_powerup: assert property (up_reg < POWERUP_CYC - 1 |-> is_nop)
        else $error("command during power-up wait");

    // Main scenarios reached
    c_read: cover property (SD_CMD == CMD_READ);
    c_write: cover property (is_wr);
    c_sleep: cover property ($fell(SD_CKE));
    c_init: cover property ($rose(INIT_DONE));
endmodule

bind sdc_ctrl sdc_ctrl_asserts #(.POWERUP_CYC(POWERUP_CYC)) sdc_ctrl_asserts_i (
    .CLK(CLK), .RSTN(RSTN), .INIT_DONE(INIT_DONE), .SD_CKE(SD_CKE), .SD_CMD(SD_CMD)
);
`default_nettype wire

// ### test/sdc_mem_model.sv
// Purpose: Behavioural four-bank SDRAM answering the sequencer's pins.
// Assumes: Burst 1, latency 2; writes with any byte masked are dropped.
// Notes:   Unwritten words read zero; an idle bus shows the inverse of its last word.
`default_nettype none
module sdc_mem_model
    import sdc_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              SD_CKE,
    input  wire sdc_pkg::sdc_cmd_t SD_CMD,
    input  wire logic [1:0]        SD_BA,
    input  wire logic [11:0]       SD_ADDR,
    input  wire logic [1:0]        SD_DQM,
    input  wire logic [15:0]       SD_DQ_O,
    input  wire logic              SD_DQ_OE,
    output logic [15:0]            SD_DQ_I
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [bit [21:0]];                 // Sparse store by bank, row, column
    logic [11:0] row_reg [4] = '{default: 12'h000}; // Open row per bank
    logic [1:0]  rdv_reg = 2'b00;                  // Read pipe, one stage per latency cycle
    logic [15:0] rdd_reg [2];                      // Read words in flight
    logic [15:0] last_reg = 16'h0000;              // Last word driven
    wire  logic [21:0] key = {SD_BA, row_reg[SD_BA], SD_ADDR[7:0]};
    wire  logic  live = SD_CKE && !SD_CMD.cs_n;    // Commands count only with clock enabled

    // Command decode on the rising edge, as the device samples it
    always @(posedge CLK) begin
        rdv_reg <= {rdv_reg[0], live && SD_CMD == CMD_READ};
        rdd_reg[1] <= rdd_reg[0];
        if (live && SD_CMD == CMD_READ) rdd_reg[0] <= mem.exists(key) ? mem[key] : 16'h0000;
        if (rdv_reg[1]) last_reg <= rdd_reg[1];
        if (live && SD_CMD == CMD_ACT) row_reg[SD_BA] <= SD_ADDR;
        if (live && SD_CMD == CMD_WRITE && SD_DQ_OE && SD_DQM == 2'b00) mem[key] = SD_DQ_O;
    end

    // Word valid at the second edge after the read, held just past it
    assign SD_DQ_I = rdv_reg[1] ? rdd_reg[1] : ~last_reg;
endmodule
`default_nettype wire

// ### test/test_sdc_ctrl.sv
// Purpose: Self-checking bench for the SDRAM command sequencer.
// Assumes: Slowest grade, 10 ns clock, shortened power-up and refresh counts.
// Notes:   Inputs change on the falling edge; the checker watches fine spacing.
`default_nettype none
module test_sdc_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import sdc_pkg::*;
    localparam int PWR  = 50;   // Shortened power-up wait
    localparam int REFI = 200;  // Shortened refresh interval
    localparam int LIM  = 2000; // Bound on every wait
    logic        clk;
    logic        rstn;
    logic        req_valid;
    sdc_req_t    req;
    logic        req_ready;
    logic        rd_valid;
    logic [15:0] rd_data;
    logic        sleep_req;
    logic        sleeping;
    logic        init_done;
    logic        sd_cke;
    sdc_cmd_t    sd_cmd;
    logic [1:0]  sd_ba;
    logic [11:0] sd_addr;
    logic [1:0]  sd_dqm;
    logic [15:0] sd_dq_o;
    logic        sd_dq_oe;
    logic [15:0] sd_dq_i;
    int          num_errors = 0;      // Mismatches
    int          samples_checked = 0; // Comparisons made
    int          cyc = 0;             // Rising edges seen
    int          last_act = 0;        // Edge of the last row open
    int          rcd_gap = 0;         // Row open to access
    int          ras_gap = 0;         // Row open to close
    int          n_ref = 0;           // Refreshes with clock enabled
    int          cke_rise = 0;        // Edge where clock enable returned
    int          first_act = 0;       // First row open since cleared
    logic        cke_q = 1'b1;        // Clock enable one edge ago

    sdc_ctrl #(.GRADE(2), .HOT_GRADE(1'b0), .AUTO_PRE_WR(1'b0), .POWERUP_CYC(PWR), .REFI_CYC(REFI)) sdc_ctrl_i (
        .CLK(clk), .RSTN(rstn), .REQ_VALID(req_valid), .REQ(req), .REQ_READY(req_ready),
        .RD_VALID(rd_valid), .RD_DATA(rd_data), .SLEEP_REQ(sleep_req), .SLEEPING(sleeping),
        .INIT_DONE(init_done), .SD_CKE(sd_cke), .SD_CMD(sd_cmd), .SD_BA(sd_ba), .SD_ADDR(sd_addr),
        .SD_DQM(sd_dqm), .SD_DQ_O(sd_dq_o), .SD_DQ_OE(sd_dq_oe), .SD_DQ_I(sd_dq_i));
    sdc_mem_model sdc_mem_model_i (
        .CLK(clk), .SD_CKE(sd_cke), .SD_CMD(sd_cmd), .SD_BA(sd_ba), .SD_ADDR(sd_addr),
        .SD_DQM(sd_dqm), .SD_DQ_O(sd_dq_o), .SD_DQ_OE(sd_dq_oe), .SD_DQ_I(sd_dq_i));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Pin monitor; sees values as the device samples them
    always @(posedge clk) begin
        cyc++;
        if (sd_cke && !cke_q) cke_rise = cyc;
        cke_q = sd_cke;
        if (sd_cmd === CMD_ACT && first_act == 0) first_act = cyc;
        if (sd_cmd === CMD_ACT) last_act = cyc;
        if (sd_cmd === CMD_READ || sd_cmd === CMD_WRITE) rcd_gap = cyc - last_act;
        if (sd_cmd === CMD_PRE) ras_gap = cyc - last_act;
        if (sd_cmd === CMD_REF && sd_cke) n_ref++;
    end

    task automatic give_verdict();
        $display("checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic fail_now(input string what);
        num_errors++;
        $display("Error at %0t: %s", $time, what);
    endtask
    task automatic too_long();
        fail_now("wait ran out");
        give_verdict();
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) fail_now($sformatf("word %h, expected %h", got, exp));
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) fail_now($sformatf("flag %b, expected %b", got, exp));
    endtask
    task automatic chk_range(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) fail_now($sformatf("count %0d outside %0d..%0d", got, lo, hi));
    endtask

    // Request held until ready shows at a falling edge; taken at the next rise
    task automatic access(input logic wr, input logic [1:0] b, input logic [11:0] r, input logic [7:0] c,
                          input logic [15:0] d);
        int i;
        req = '{write: wr, bank: b, row: r, col: c, wdata: d};
        req_valid = 1'b1;
        for (i = 0; i < LIM && !(req_ready === 1'b1 && init_done === 1'b1); i++) @(negedge clk);
        if (i == LIM) too_long();
        @(negedge clk);
        req_valid = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd_chk(input logic [1:0] b, input logic [11:0] r, input logic [7:0] c, input logic [15:0] e);
        int i;
        access(1'b0, b, r, c, 16'h0000);
        for (i = 0; i < LIM && rd_valid !== 1'b1; i++) @(negedge clk);
        if (i == LIM) too_long();
        chk_word(rd_data, e);
    endtask

    // Power-up wait and init refreshes before the first request
    task automatic t_init();
        int i;
        for (i = 0; i < LIM && init_done !== 1'b1; i++) @(negedge clk);
        if (i == LIM) too_long();
        chk_range(i, PWR, LIM);
        chk_range(n_ref, 2, 3);
        $display("test init finished");
    endtask
    // Every bank at the top column, rows counting down from the top, writes back to back
    task automatic t_banks();
        int b;
        for (b = 0; b < 4; b++) access(1'b1, b[1:0], 12'hfff - b[11:0], 8'hff, 16'ha5c3 ^ b[15:0]);
        for (b = 0; b < 4; b++) begin
            rd_chk(b[1:0], 12'hfff - b[11:0], 8'hff, 16'ha5c3 ^ b[15:0]);
            chk_range(rcd_gap, 2, 8);
            chk_range(ras_gap, 5, 10000);
        end
        $display("test banks finished");
    endtask
    // Overwrite then read one word at once, and an untouched word
    task automatic t_b2b();
        access(1'b1, 2'b01, 12'h000, 8'h00, 16'h0001);
        rd_chk(2'b01, 12'h000, 8'h00, 16'h0001);
        access(1'b1, 2'b01, 12'h000, 8'h00, 16'hfffe);
        rd_chk(2'b01, 12'h000, 8'h00, 16'hfffe);
        rd_chk(2'b10, 12'h123, 8'h45, 16'h0000);
        $display("test back to back finished");
    endtask
    // Idle for three refresh intervals
    task automatic t_refresh();
        int n0;
        n0 = n_ref;
        repeat (3 * REFI) @(negedge clk);
        chk_range(n_ref - n0, 2, 4);
        $display("test refresh finished");
    endtask
    // Self refresh, then exit and read back held data
    task automatic t_sleep();
        int i;
        sleep_req = 1'b1;
        for (i = 0; i < LIM && sleeping !== 1'b1; i++) @(negedge clk);
        if (i == LIM) too_long();
        repeat (20) @(negedge clk);
        chk_bit(sd_cke, 1'b0);
        chk_bit(req_ready, 1'b0);
        first_act = 0;
        sleep_req = 1'b0;
        for (i = 0; i < LIM && sleeping !== 1'b0; i++) @(negedge clk);
        if (i == LIM) too_long();
        rd_chk(2'b00, 12'hfff, 8'hff, 16'ha5c3);
        chk_range(first_act - cke_rise, 7, 200);
        $display("test sleep finished");
    endtask

    initial begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        sleep_req = 1'b0;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        t_init();
        t_banks();
        t_b2b();
        t_refresh();
        t_sleep();
        give_verdict();
    end
endmodule
`default_nettype wire
